//--- rtl/crf_regs.svh
// Purpose: constants for the core register and flag file
// Assumes: included by bare name from the design files
// Notes: header holds definitions only
// Operation
// - eight identical 32-bit general registers
// - each splits into extended and base halves
// - base half splits into high, low bytes
// - eighth register doubles as stack pointer
// - 24-bit pointer, fetch ignores bit zero
// - flag bit 7 masks all but NMI
// - exception entry sets flag bit 7
// - bits 6 and 4 are user bits
// - half carry from bit 3, 11, 27
// - negative flag takes result sign bit
// - zero flag set on zero result
// - overflow flag set on arithmetic overflow
// - carry flag on carry, borrow, shift out
// - carry flag is bit accumulator
// - flags kept, loaded, stored, and/or/xor
// - branches test negative, zero, overflow, carry
// - reset loads pointer, sets mask bit only
// - normal 64-kbyte or advanced 16-Mbyte mode
// - 1-Mbyte mode drops upper four address bits
// - sleep instruction enters power-down state
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH
`define CRF_NUM_GPR      8
`define CRF_SP_INDEX     3'h7
`define CRF_BIT_I        7
`define CRF_BIT_UI       6
`define CRF_BIT_H        5
`define CRF_BIT_U        4
`define CRF_BIT_N        3
`define CRF_BIT_Z        2
`define CRF_BIT_V        1
`define CRF_BIT_C        0
`define CRF_ADDR_NORMAL  24'h00FFFF
`define CRF_ADDR_1MB     24'h0FFFFF
`define CRF_ADDR_ADV     24'hFFFFFF
`endif

//--- rtl/crf_pkg.sv
// Purpose: types for the core register and flag file
// Assumes: nothing
// Notes: none
`default_nettype none
package crf_pkg;
    typedef enum logic [1:0] {
        CRF_SZ_BYTE,
        CRF_SZ_WORD,
        CRF_SZ_LONG
    } crf_size_t;
    // flag update sources
    typedef enum logic [2:0] {
        CRF_FL_KEEP,
        CRF_FL_ARITH,
        CRF_FL_LOGIC,
        CRF_FL_SHIFT,
        CRF_FL_LOAD,
        CRF_FL_AND,
        CRF_FL_OR,
        CRF_FL_XOR
    } crf_flop_t;
    typedef enum logic [1:0] {
        CRF_MODE_NORMAL,
        CRF_MODE_ADV,
        CRF_MODE_1MB
    } crf_mode_t;
    typedef enum logic [3:0] {
        CRF_CC_T, CRF_CC_F, CRF_CC_HI, CRF_CC_LS,
        CRF_CC_CC, CRF_CC_CS, CRF_CC_NE, CRF_CC_EQ,
        CRF_CC_VC, CRF_CC_VS, CRF_CC_PL, CRF_CC_MI,
        CRF_CC_GE, CRF_CC_LT, CRF_CC_GT, CRF_CC_LE
    } crf_cond_t;
    typedef enum logic [1:0] {
        CRF_ST_RESET,
        CRF_ST_RUN,
        CRF_ST_SLEEP
    } crf_state_t;
endpackage
`default_nettype wire

//--- rtl/crf_gpr_mem.sv
// Purpose: eight 32-bit general registers with sized views
// Assumes: one write port, two registered read ports and a registered stack pointer read
// Notes: registers not reset; narrow writes merge into old value
`default_nettype none
`include "crf_regs.svh"
module crf_gpr_mem
    import crf_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              wr_en,
    input  wire logic [3:0]        wr_sel,
    input  wire crf_pkg::crf_size_t wr_size,
    input  wire logic [31:0]       wr_data,
    input  wire logic [2:0]        rd_idx_a,
    input  wire logic [2:0]        rd_idx_b,
    output logic [31:0]            rd_data_a,
    output logic [31:0]            rd_data_b,
    output logic [31:0]            sp_data
);
    logic [31:0] gpr_reg [`CRF_NUM_GPR];
    logic [2:0]  wr_idx;
    logic [31:0] wr_old;
    logic [31:0] wr_merged;
    // long: sel[2:0]; word: sel[3] picks extended half; byte: sel[3] high
    assign wr_idx = wr_sel[2:0];
    assign wr_old = gpr_reg[wr_idx];
    always_comb begin
        wr_merged = wr_old;
        case (wr_size)
            CRF_SZ_LONG: wr_merged = wr_data;
            CRF_SZ_WORD: begin
                if (wr_sel[3]) begin
                    wr_merged[31:16] = wr_data[15:0];
                end else begin
                    wr_merged[15:0] = wr_data[15:0];
                end
            end
            CRF_SZ_BYTE: begin
                if (wr_sel[3]) begin
                    wr_merged[15:8] = wr_data[7:0];
                end else begin
                    wr_merged[7:0] = wr_data[7:0];
                end
            end
            default: wr_merged = wr_old;
        endcase
    end
    always_ff @(posedge clk) begin
        if (wr_en) begin
            gpr_reg[wr_idx] <= wr_merged;
        end
    end
    always_ff @(posedge clk) begin
        rd_data_a <= gpr_reg[rd_idx_a];
        rd_data_b <= gpr_reg[rd_idx_b];
        sp_data   <= gpr_reg[`CRF_SP_INDEX];
    end
endmodule
`default_nettype wire

//--- rtl/crf_core_regs.sv
// Purpose: architectural register and flag file of the core
// Assumes: datapath supplies operands, results and control strobes
// Notes: general registers uninitialised; of the flags only the mask bit resets, other registers clear
`default_nettype none
`include "crf_regs.svh"
module crf_core_regs
    import crf_pkg::*;
(
    input  wire logic               CLK_SYS,
    input  wire logic               SRST,
    input  wire logic [23:0]        RESET_VECTOR,
    input  wire crf_pkg::crf_mode_t MODE,
    input  wire logic               GPR_WR_EN,
    input  wire logic [3:0]         GPR_WR_SEL,
    input  wire crf_pkg::crf_size_t GPR_WR_SIZE,
    input  wire logic [31:0]        GPR_WR_DATA,
    input  wire logic [2:0]         GPR_RD_IDX_A,
    input  wire logic [2:0]         GPR_RD_IDX_B,
    output logic [31:0]             GPR_RD_A,
    output logic [31:0]             GPR_RD_B,
    output logic [31:0]             STACK_POINTER,
    input  wire logic               PC_LOAD,
    input  wire logic [23:0]        PC_LOAD_VAL,
    input  wire logic               PC_ADVANCE,
    input  wire logic [23:0]        PC_STEP,
    output logic [23:0]             NEXT_INSTRUCTION_POINTER,
    output logic [23:0]             FETCH_ADDR,
    input  wire logic [23:0]        EA_IN,
    output logic [23:0]             EA_OUT,
    input  wire crf_pkg::crf_flop_t FLAG_OP,
    input  wire crf_pkg::crf_size_t FLAG_SIZE,
    input  wire logic [31:0]        OPND_A,
    input  wire logic [31:0]        OPND_B,
    input  wire logic [31:0]        RESULT,
    input  wire logic               IS_SUB,
    input  wire logic               SHIFT_OUT,
    input  wire logic [7:0]         FLAG_IMM,
    input  wire logic               BIT_ACC_WR,
    input  wire logic               BIT_ACC_VAL,
    input  wire logic               EXC_START,
    input  wire crf_pkg::crf_cond_t BR_COND,
    output logic                    BR_TAKEN,
    input  wire logic               IRQ_REQ,
    input  wire logic               NMI_REQ,
    output logic                    IRQ_ACCEPT,
    output logic                    USER_MASK,
    input  wire logic               SLEEP_EXEC,
    input  wire logic               WAKE,
    output logic                    POWER_DOWN,
    output logic [7:0]              CONDITION_CODE_FLAGS,
    output logic                    BIT_ACC
);
    logic [7:0]  ccr_reg;
    logic [7:0]  ccr_next;
    logic [23:0] pc_reg;
    logic [23:0] pc_next;
    crf_state_t  st_reg;
    crf_state_t  st_next;
    logic        br_taken_reg;
    logic        irq_acc_reg;
    logic        pd_reg;
    logic [23:0] ea_reg;
    logic [23:0] fetch_reg;

    crf_gpr_mem u_gpr (
        .clk       (CLK_SYS),
        .wr_en     (GPR_WR_EN),
        .wr_sel    (GPR_WR_SEL),
        .wr_size   (GPR_WR_SIZE),
        .wr_data   (GPR_WR_DATA),
        .rd_idx_a  (GPR_RD_IDX_A),
        .rd_idx_b  (GPR_RD_IDX_B),
        .rd_data_a (GPR_RD_A),
        .rd_data_b (GPR_RD_B),
        .sp_data   (STACK_POINTER)
    );

    // sign, zero and carry positions per operand size
    wire        sign_r;
    wire        sign_a;
    wire        sign_b;
    wire        zero_r;
    wire        hc_bit;
    wire        cy_bit;
    wire [32:0] bx;
    wire        a_h;
    wire        b_h;
    wire        r_h;
    assign bx = {1'b0, IS_SUB ? ~OPND_B : OPND_B};
    assign sign_r = (FLAG_SIZE == CRF_SZ_BYTE) ? RESULT[7] :
                    (FLAG_SIZE == CRF_SZ_WORD) ? RESULT[15] : RESULT[31];
    assign sign_a = (FLAG_SIZE == CRF_SZ_BYTE) ? OPND_A[7] :
                    (FLAG_SIZE == CRF_SZ_WORD) ? OPND_A[15] : OPND_A[31];
    assign sign_b = (FLAG_SIZE == CRF_SZ_BYTE) ? bx[7] :
                    (FLAG_SIZE == CRF_SZ_WORD) ? bx[15] : bx[31];
    assign zero_r = (FLAG_SIZE == CRF_SZ_BYTE) ? (RESULT[7:0] == 8'h00) :
                    (FLAG_SIZE == CRF_SZ_WORD) ? (RESULT[15:0] == 16'h0000) :
                    (RESULT == 32'h0000_0000);
    // half-carry boundary bits 3, 11 or 27
    assign a_h = (FLAG_SIZE == CRF_SZ_BYTE) ? OPND_A[3] :
                 (FLAG_SIZE == CRF_SZ_WORD) ? OPND_A[11] : OPND_A[27];
    assign b_h = (FLAG_SIZE == CRF_SZ_BYTE) ? bx[3] :
                 (FLAG_SIZE == CRF_SZ_WORD) ? bx[11] : bx[27];
    assign r_h = (FLAG_SIZE == CRF_SZ_BYTE) ? RESULT[3] :
                 (FLAG_SIZE == CRF_SZ_WORD) ? RESULT[11] : RESULT[27];
    // carry out of a bit from its own bits only, so upper bits do not leak
    wire hc_raw;
    assign hc_raw = (a_h & b_h) | ((a_h | b_h) & ~r_h);
    wire cy_raw;
    assign cy_raw = (sign_a & sign_b) | ((sign_a | sign_b) & ~sign_r);
    assign hc_bit = IS_SUB ? ~hc_raw : hc_raw;
    assign cy_bit = IS_SUB ? ~cy_raw : cy_raw;
    wire ovf_bit;
    assign ovf_bit = (sign_a == sign_b) && (sign_r != sign_a);

    always_comb begin
        ccr_next = ccr_reg;
        case (FLAG_OP)
            CRF_FL_KEEP: ccr_next = ccr_reg;
            CRF_FL_ARITH: begin
                ccr_next[`CRF_BIT_H] = hc_bit;
                ccr_next[`CRF_BIT_N] = sign_r;
                ccr_next[`CRF_BIT_Z] = zero_r;
                ccr_next[`CRF_BIT_V] = ovf_bit;
                ccr_next[`CRF_BIT_C] = cy_bit;
            end
            CRF_FL_LOGIC: begin
                ccr_next[`CRF_BIT_N] = sign_r;
                ccr_next[`CRF_BIT_Z] = zero_r;
                ccr_next[`CRF_BIT_V] = 1'b0;
            end
            CRF_FL_SHIFT: begin
                ccr_next[`CRF_BIT_N] = sign_r;
                ccr_next[`CRF_BIT_Z] = zero_r;
                ccr_next[`CRF_BIT_V] = 1'b0;
                ccr_next[`CRF_BIT_C] = SHIFT_OUT;
            end
            CRF_FL_LOAD: ccr_next = FLAG_IMM;
            CRF_FL_AND:  ccr_next = ccr_reg & FLAG_IMM;
            CRF_FL_OR:   ccr_next = ccr_reg | FLAG_IMM;
            CRF_FL_XOR:  ccr_next = ccr_reg ^ FLAG_IMM;
            default:     ccr_next = ccr_reg;
        endcase
        if (BIT_ACC_WR) begin
            ccr_next[`CRF_BIT_C] = BIT_ACC_VAL;
        end
        if (EXC_START) begin
            ccr_next[`CRF_BIT_I] = 1'b1;
        end
    end

    // only the mask bit has a reset value
    always_ff @(posedge CLK_SYS) begin
        ccr_reg <= ccr_next;
        if (SRST) begin
            ccr_reg[`CRF_BIT_I] <= 1'b1;
        end
    end

    // pointer state machine: reset vector, run, sleep
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            CRF_ST_RESET: st_next = CRF_ST_RUN;
            CRF_ST_RUN: begin
                if (SLEEP_EXEC) begin
                    st_next = CRF_ST_SLEEP;
                end
            end
            CRF_ST_SLEEP: begin
                if (WAKE || NMI_REQ) begin
                    st_next = CRF_ST_RUN;
                end
            end
            default: st_next = CRF_ST_RESET;
        endcase
    end

    wire [23:0] addr_mask;
    assign addr_mask = (MODE == CRF_MODE_NORMAL) ? `CRF_ADDR_NORMAL :
                       (MODE == CRF_MODE_1MB) ? `CRF_ADDR_1MB :
                       `CRF_ADDR_ADV;
    wire [23:0] pc_sum;
    assign pc_sum = pc_reg + PC_STEP;
    always_comb begin
        pc_next = pc_reg;
        if (st_reg == CRF_ST_RESET) begin
            pc_next = RESET_VECTOR;
        end else if (PC_LOAD) begin
            pc_next = PC_LOAD_VAL & addr_mask;
        end else if (PC_ADVANCE && st_reg == CRF_ST_RUN) begin
            pc_next = pc_sum & addr_mask;
        end
    end

    wire cc_n;
    wire cc_z;
    wire cc_v;
    wire cc_c;
    logic br_eval;
    assign cc_n = ccr_reg[`CRF_BIT_N];
    assign cc_z = ccr_reg[`CRF_BIT_Z];
    assign cc_v = ccr_reg[`CRF_BIT_V];
    assign cc_c = ccr_reg[`CRF_BIT_C];
    always_comb begin
        case (BR_COND)
            CRF_CC_T:  br_eval = 1'b1;
            CRF_CC_F:  br_eval = 1'b0;
            CRF_CC_HI: br_eval = ~(cc_c | cc_z);
            CRF_CC_LS: br_eval = cc_c | cc_z;
            CRF_CC_CC: br_eval = ~cc_c;
            CRF_CC_CS: br_eval = cc_c;
            CRF_CC_NE: br_eval = ~cc_z;
            CRF_CC_EQ: br_eval = cc_z;
            CRF_CC_VC: br_eval = ~cc_v;
            CRF_CC_VS: br_eval = cc_v;
            CRF_CC_PL: br_eval = ~cc_n;
            CRF_CC_MI: br_eval = cc_n;
            CRF_CC_GE: br_eval = ~(cc_n ^ cc_v);
            CRF_CC_LT: br_eval = cc_n ^ cc_v;
            CRF_CC_GT: br_eval = ~(cc_z | (cc_n ^ cc_v));
            CRF_CC_LE: br_eval = cc_z | (cc_n ^ cc_v);
            default:   br_eval = 1'b0;
        endcase
    end
    wire irq_ok;
    assign irq_ok = NMI_REQ || (IRQ_REQ && !ccr_reg[`CRF_BIT_I]);

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            st_reg       <= CRF_ST_RESET;
            pc_reg       <= 24'h00_0000;
            br_taken_reg <= 1'b0;
            irq_acc_reg  <= 1'b0;
            pd_reg       <= 1'b0;
            ea_reg       <= 24'h00_0000;
            fetch_reg    <= 24'h00_0000;
        end else begin
            st_reg       <= st_next;
            pc_reg       <= pc_next;
            br_taken_reg <= br_eval;
            irq_acc_reg  <= irq_ok;
            pd_reg       <= (st_next == CRF_ST_SLEEP);
            ea_reg       <= EA_IN & addr_mask;
            fetch_reg    <= {pc_next[23:1], 1'b0};
        end
    end

    assign NEXT_INSTRUCTION_POINTER = pc_reg;
    assign FETCH_ADDR = fetch_reg;
    assign EA_OUT = ea_reg;
    assign CONDITION_CODE_FLAGS = ccr_reg;
    assign BIT_ACC = ccr_reg[`CRF_BIT_C];
    assign USER_MASK = ccr_reg[`CRF_BIT_UI];
    assign BR_TAKEN = br_taken_reg;
    assign IRQ_ACCEPT = irq_acc_reg;
    assign POWER_DOWN = pd_reg;

    property mask_set_p;
        @(posedge CLK_SYS) disable iff (SRST)
        EXC_START |=> ccr_reg[`CRF_BIT_I];
    endproperty
    exc_mask_a: assert property (mask_set_p)
        else $error("mask bit not set after exception start");
    reset_mask_a: assert property (@(posedge CLK_SYS)
        SRST |=> ccr_reg[`CRF_BIT_I])
        else $error("mask bit not set by reset");
    reset_vec_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        st_reg == CRF_ST_RESET |=> pc_reg == $past(RESET_VECTOR))
        else $error("pointer not loaded from vector");
    fetch_even_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        FETCH_ADDR[0] == 1'b0)
        else $error("fetch address odd");
    irq_gate_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        IRQ_REQ && !NMI_REQ && ccr_reg[`CRF_BIT_I] |=> !IRQ_ACCEPT)
        else $error("masked interrupt accepted");
    nmi_pass_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        NMI_REQ |=> IRQ_ACCEPT)
        else $error("nmi not accepted");
    flags_keep_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        FLAG_OP == CRF_FL_KEEP && !BIT_ACC_WR && !EXC_START
        |=> $stable(ccr_reg))
        else $error("flags changed on keep");
    zero_flag_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        FLAG_OP == CRF_FL_ARITH && zero_r |=> ccr_reg[`CRF_BIT_Z])
        else $error("zero flag not set");
    bit_acc_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        BIT_ACC_WR |=> BIT_ACC == $past(BIT_ACC_VAL))
        else $error("bit accumulator not written");
    sleep_enter_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        st_reg == CRF_ST_RUN && SLEEP_EXEC |=> POWER_DOWN)
        else $error("sleep did not power down");
    normal_addr_a: assert property (@(posedge CLK_SYS) disable iff (SRST)
        MODE == CRF_MODE_NORMAL |=> EA_OUT[23:16] == 8'h00)
        else $error("normal mode address too wide");
    sleep_c: cover property (@(posedge CLK_SYS) SLEEP_EXEC ##1 POWER_DOWN);
    exc_c: cover property (@(posedge CLK_SYS) EXC_START ##1 NMI_REQ);
    branch_c: cover property (@(posedge CLK_SYS) BR_TAKEN);
endmodule
`default_nettype wire

//--- dv/crf_alu_model.sv
// Purpose: datapath adder model feeding result and expected flags
// Assumes: operands held steady by the bench for a whole cycle
// Notes: flags packed as half, negative, zero, overflow, carry
`default_nettype none
module crf_alu_model
    import crf_pkg::*;
(
    input  wire crf_pkg::crf_size_t size,
    input  wire logic [31:0]        a,
    input  wire logic [31:0]        b,
    input  wire logic               is_sub,
    output logic [31:0]             result,
    output logic [4:0]              hnzvc
);
    timeunit 1ns;
    timeprecision 1ps;
    int          w;
    logic [32:0] sum;
    logic [31:0] msk;
    logic [31:0] am;
    logic [31:0] bm;
    logic [31:0] hm;
    always_comb begin
        w = (size == CRF_SZ_BYTE) ? 8 : (size == CRF_SZ_WORD) ? 16 : 32;
        msk = (w == 32) ? 32'hFFFFFFFF : (32'h1 << w) - 32'h1;
        hm = msk >> 4;
        am = a & msk;
        bm = b & msk;
        sum = is_sub ? {1'b0, am} - {1'b0, bm} : {1'b0, am} + {1'b0, bm};
        result = sum[31:0] & msk;
        // carry or borrow out of bit 3, 11 or 27
        hnzvc[4] = is_sub ? ((am & hm) < (bm & hm))
                          : (((am & hm) + (bm & hm)) > hm);
        hnzvc[3] = result[w-1];
        hnzvc[2] = (result == 32'h0);
        hnzvc[1] = ((am[w-1] ^ bm[w-1]) == is_sub)
                   && (result[w-1] != am[w-1]);
        hnzvc[0] = is_sub ? (am < bm) : sum[w];
    end
endmodule
`default_nettype wire

//--- dv/cpu_register_and_flag_file_bench.sv
// Purpose: self-checking bench of the core register and flag file
// Assumes: datapath arithmetic comes from crf_alu_model
// Notes: inputs change by non-blocking assignment on rising edges
`default_nettype none
module cpu_register_and_flag_file_bench;
    import crf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        CLK_SYS = 1'b0, SRST = 1'b1, GPR_WR_EN = 1'b0;
    logic        PC_LOAD = 1'b0, PC_ADVANCE = 1'b0, IS_SUB = 1'b0;
    logic        SHIFT_OUT = 1'b0, BIT_ACC_WR = 1'b0, BIT_ACC_VAL = 1'b0;
    logic        EXC_START = 1'b0, IRQ_REQ = 1'b0, NMI_REQ = 1'b0;
    logic        SLEEP_EXEC = 1'b0, WAKE = 1'b0;
    logic [23:0] RESET_VECTOR = 24'h123457, PC_LOAD_VAL = 24'h0;
    logic [23:0] PC_STEP = 24'h2, EA_IN = 24'h0;
    logic [3:0]  GPR_WR_SEL = 4'h0;
    logic [2:0]  GPR_RD_IDX_A = 3'h0, GPR_RD_IDX_B = 3'h0;
    logic [31:0] GPR_WR_DATA = 32'h0, OPND_A = 32'h0, OPND_B = 32'h0;
    logic [7:0]  FLAG_IMM = 8'h0;
    crf_mode_t   MODE = CRF_MODE_ADV;
    crf_size_t   GPR_WR_SIZE = CRF_SZ_LONG, FLAG_SIZE = CRF_SZ_LONG;
    crf_flop_t   FLAG_OP = CRF_FL_KEEP;
    crf_cond_t   BR_COND = CRF_CC_T;
    logic [31:0] GPR_RD_A, GPR_RD_B, STACK_POINTER, RESULT;
    logic [23:0] NEXT_INSTRUCTION_POINTER, FETCH_ADDR, EA_OUT;
    logic [7:0]  CONDITION_CODE_FLAGS;
    logic [4:0]  exp_hnzvc;
    logic        BR_TAKEN, IRQ_ACCEPT, USER_MASK, POWER_DOWN, BIT_ACC;
    int          err_total = 0, compares = 0, cycles = 0;

    crf_core_regs dut_u (
        .CLK_SYS, .SRST, .RESET_VECTOR, .MODE, .GPR_WR_EN, .GPR_WR_SEL,
        .GPR_WR_SIZE, .GPR_WR_DATA, .GPR_RD_IDX_A, .GPR_RD_IDX_B,
        .GPR_RD_A, .GPR_RD_B, .STACK_POINTER, .PC_LOAD, .PC_LOAD_VAL,
        .PC_ADVANCE, .PC_STEP, .NEXT_INSTRUCTION_POINTER, .FETCH_ADDR,
        .EA_IN, .EA_OUT, .FLAG_OP, .FLAG_SIZE, .OPND_A, .OPND_B, .RESULT,
        .IS_SUB, .SHIFT_OUT, .FLAG_IMM, .BIT_ACC_WR, .BIT_ACC_VAL,
        .EXC_START, .BR_COND, .BR_TAKEN, .IRQ_REQ, .NMI_REQ, .IRQ_ACCEPT,
        .USER_MASK, .SLEEP_EXEC, .WAKE, .POWER_DOWN,
        .CONDITION_CODE_FLAGS, .BIT_ACC
    );
    crf_alu_model alu_u (
        .size(FLAG_SIZE), .a(OPND_A), .b(OPND_B), .is_sub(IS_SUB),
        .result(RESULT), .hnzvc(exp_hnzvc)
    );

    always #25 CLK_SYS = ~CLK_SYS;
    always @(posedge CLK_SYS) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            err_total++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cyc(input int n = 1);
        repeat (n) @(posedge CLK_SYS);
    endtask
    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] got);
        compares++;
        if (got !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask
    task automatic do_reset(input logic [23:0] v);
        cyc();
        SRST <= 1'b1;
        RESET_VECTOR <= v;
        cyc(12);
        SRST <= 1'b0;
        cyc();
        #1;
        chk("pointer", v, NEXT_INSTRUCTION_POINTER);
        chk("fetch", {v[23:1], 1'b0}, FETCH_ADDR);
        chk("mask bit", 1'b1, CONDITION_CODE_FLAGS[7]);
    endtask
    task automatic fl(input crf_flop_t op, input logic [7:0] imm,
                      input crf_size_t sz, input logic [31:0] a, b,
                      input logic sub, sh, bw);
        cyc();
        FLAG_OP <= op;
        FLAG_IMM <= imm;
        FLAG_SIZE <= sz;
        OPND_A <= a;
        OPND_B <= b;
        IS_SUB <= sub;
        SHIFT_OUT <= sh;
        BIT_ACC_VAL <= sh;
        BIT_ACC_WR <= bw;
        cyc();
        FLAG_OP <= CRF_FL_KEEP;
        BIT_ACC_WR <= 1'b0;
        #1;
    endtask
    task automatic condition_code_flags(input crf_flop_t op, input logic [7:0] imm, e);
        fl(op, imm, CRF_SZ_LONG, 32'h0, 32'h0, 1'b0, 1'b0, 1'b0);
        chk("flags", e, CONDITION_CODE_FLAGS);
        chk("user mask", e[6], USER_MASK);
        chk("bit acc", e[0], BIT_ACC);
    endtask
    task automatic ar(input crf_size_t sz, input logic [31:0] a, b,
                      input logic sub);
        fl(CRF_FL_ARITH, 8'h0, sz, a, b, sub, 1'b0, 1'b0);
        chk("arith flags", exp_hnzvc,
            {CONDITION_CODE_FLAGS[5], CONDITION_CODE_FLAGS[3:0]});
        chk("kept bits", 3'b011,
            {CONDITION_CODE_FLAGS[7:6], CONDITION_CODE_FLAGS[4]});
    endtask
    task automatic wr(input logic [3:0] sel, input crf_size_t sz,
                      input logic [31:0] d, e, input logic [31:0] sp);
        cyc();
        GPR_WR_EN <= 1'b1;
        GPR_WR_SEL <= sel;
        GPR_WR_SIZE <= sz;
        GPR_WR_DATA <= d;
        cyc();
        GPR_WR_EN <= 1'b0;
        GPR_RD_IDX_A <= sel[2:0];
        GPR_RD_IDX_B <= 3'h7;
        cyc();
        #1;
        chk("gpr port a", e, GPR_RD_A);
        chk("gpr port b", sp, GPR_RD_B);
        chk("stack pointer", sp, STACK_POINTER);
    endtask
    function automatic logic br_exp(input int c, input logic [3:0] f);
        logic n, z, v, k;
        logic [15:0] t;
        {n, z, v, k} = f;
        t = {z | (n ^ v), !(z | (n ^ v)), n ^ v, !(n ^ v), n, !n, v, !v,
             z, !z, k, !k, k | z, !(k | z), 1'b0, 1'b1};
        return t[c];
    endfunction

    task automatic t_gpr;
        wr(4'h7, CRF_SZ_LONG, 32'h11223344, 32'h11223344, 32'h11223344);
        wr(4'hF, CRF_SZ_WORD, 32'h0000AAAA, 32'hAAAA3344, 32'hAAAA3344);
        wr(4'hF, CRF_SZ_BYTE, 32'h00000055, 32'hAAAA5544, 32'hAAAA5544);
        wr(4'h7, CRF_SZ_BYTE, 32'h00000066, 32'hAAAA5566, 32'hAAAA5566);
        wr(4'h7, CRF_SZ_WORD, 32'h0000BEEF, 32'hAAAABEEF, 32'hAAAABEEF);
        wr(4'hB, CRF_SZ_LONG, 32'hCAFE0001, 32'hCAFE0001, 32'hAAAABEEF);
    endtask
    task automatic t_flags;
        condition_code_flags(CRF_FL_LOAD, 8'h5A, 8'h5A);
        condition_code_flags(CRF_FL_AND, 8'hF0, 8'h50);
        condition_code_flags(CRF_FL_OR, 8'h81, 8'hD1);
        condition_code_flags(CRF_FL_XOR, 8'hFF, 8'h2E);
        condition_code_flags(CRF_FL_KEEP, 8'h33, 8'h2E);
    endtask
    task automatic t_arith;
        condition_code_flags(CRF_FL_LOAD, 8'h50, 8'h50);
        ar(CRF_SZ_BYTE, 32'hABCDEF0F, 32'h00000001, 1'b0);
        ar(CRF_SZ_BYTE, 32'h0000007F, 32'h00000001, 1'b0);
        ar(CRF_SZ_BYTE, 32'h00000000, 32'h00000001, 1'b1);
        ar(CRF_SZ_WORD, 32'h00000F00, 32'h00000100, 1'b0);
        ar(CRF_SZ_WORD, 32'h00001234, 32'h00001234, 1'b1);
        ar(CRF_SZ_LONG, 32'h08000000, 32'h08000000, 1'b0);
        ar(CRF_SZ_LONG, 32'hFFFFFFFF, 32'h00000001, 1'b0);
        ar(CRF_SZ_LONG, 32'h80000000, 32'h00000001, 1'b1);
    endtask
    task automatic t_shift;
        condition_code_flags(CRF_FL_LOAD, 8'h03, 8'h03);
        fl(CRF_FL_LOGIC, 8'h0, CRF_SZ_BYTE, 32'h80, 32'h0, 1'b0, 1'b0, 1'b0);
        chk("logic nzv", 3'b100, CONDITION_CODE_FLAGS[3:1]);
        fl(CRF_FL_SHIFT, 8'h0, CRF_SZ_LONG, 32'h0, 32'h0, 1'b0, 1'b1, 1'b0);
        chk("shift nzvc", 4'h5, CONDITION_CODE_FLAGS[3:0]);
        fl(CRF_FL_LOAD, 8'h0, CRF_SZ_LONG, 32'h0, 32'h0, 1'b0, 1'b1, 1'b1);
        chk("bit acc write", 8'h01, CONDITION_CODE_FLAGS);
    endtask
    task automatic t_branch;
        for (int p = 0; p < 2; p++) begin
            condition_code_flags(CRF_FL_LOAD, p ? 8'h05 : 8'h0A, p ? 8'h05 : 8'h0A);
            for (int c = 0; c < 16; c++) begin
                cyc();
                BR_COND <= crf_cond_t'(c);
                cyc();
                #1;
                chk("branch", br_exp(c, CONDITION_CODE_FLAGS[3:0]),
                    BR_TAKEN);
            end
        end
    endtask
    task automatic t_irq;
        condition_code_flags(CRF_FL_LOAD, 8'h00, 8'h00);
        cyc();
        IRQ_REQ <= 1'b1;
        cyc();
        #1;
        chk("irq open", 1'b1, IRQ_ACCEPT);
        cyc();
        EXC_START <= 1'b1;
        FLAG_OP <= CRF_FL_LOAD;
        cyc();
        EXC_START <= 1'b0;
        FLAG_OP <= CRF_FL_KEEP;
        #1;
        chk("exception mask", 1'b1, CONDITION_CODE_FLAGS[7]);
        cyc();
        #1;
        chk("irq masked", 1'b0, IRQ_ACCEPT);
        cyc();
        NMI_REQ <= 1'b1;
        cyc();
        #1;
        chk("nmi taken", 1'b1, IRQ_ACCEPT);
        cyc();
        IRQ_REQ <= 1'b0;
        NMI_REQ <= 1'b0;
    endtask
    task automatic t_pc;
        crf_mode_t   m[3] = '{CRF_MODE_NORMAL, CRF_MODE_1MB, CRF_MODE_ADV};
        logic [23:0] k[3] = '{24'h00FFFF, 24'h0FFFFF, 24'hFFFFFF};
        for (int i = 0; i < 3; i++) begin
            cyc();
            MODE <= m[i];
            PC_LOAD <= 1'b1;
            PC_LOAD_VAL <= 24'hABCDEF;
            EA_IN <= 24'hFEDCBA;
            cyc();
            PC_LOAD <= 1'b0;
            PC_ADVANCE <= 1'b1;
            cyc();
            PC_ADVANCE <= 1'b0;
            #1;
            chk("pointer", (24'hABCDEF & k[i]) + 24'h2,
                NEXT_INSTRUCTION_POINTER);
            chk("fetch", (24'hABCDF0 & k[i]), FETCH_ADDR);
            chk("address", 24'hFEDCBA & k[i], EA_OUT);
        end
    endtask
    task automatic t_sleep;
        logic [23:0] p0;
        p0 = NEXT_INSTRUCTION_POINTER;
        cyc();
        SLEEP_EXEC <= 1'b1;
        cyc();
        SLEEP_EXEC <= 1'b0;
        PC_ADVANCE <= 1'b1;
        cyc(2);
        #1;
        chk("power down", 1'b1, POWER_DOWN);
        chk("pointer held", p0, NEXT_INSTRUCTION_POINTER);
        cyc();
        PC_ADVANCE <= 1'b0;
        WAKE <= 1'b1;
        cyc();
        WAKE <= 1'b0;
        #1;
        chk("woken", 1'b0, POWER_DOWN);
    endtask

    initial begin
        do_reset(24'h123457);
        t_gpr();
        t_flags();
        t_arith();
        t_shift();
        t_branch();
        t_irq();
        t_pc();
        t_sleep();
        condition_code_flags(CRF_FL_LOAD, 8'h00, 8'h00);
        do_reset(24'h000100);
        wrap_up();
    end
endmodule
`default_nettype wire
